//--- core/pd_setting_resolve.sv
`timescale 1ns/1ps
`default_nettype none

module pd_setting_resolve
(
    input wire logic [11:0] pd_word_in,
    input wire logic alt_mode_in,
    output var servo_cfg_pkg::pd_cfg_type pd_cfg_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Field views
    wire logic enh_on = pd_word_in[servo_cfg_pkg::ENH_BIT];
    wire logic [2:0] str_code = pd_word_in[servo_cfg_pkg::STR_MSB:servo_cfg_pkg::STR_LSB];
    wire logic [1:0] ll_code = pd_word_in[servo_cfg_pkg::LL_MSB:servo_cfg_pkg::LL_LSB];
    wire logic prog_on = enh_on && !alt_mode_in;

    // Lowpass corner: upper bit only, and only when programmable
    assign pd_cfg_out.phase_det_lowpass_sel = prog_on && pd_word_in[servo_cfg_pkg::PDLP_BIT]; // R06 R10

    // Stretcher: legacy fixed 3.8 ns, normal table, or reversed table
    assign pd_cfg_out.pulse_stretch_time = alt_mode_in ? servo_cfg_pkg::stretch_decode(str_code, 1'b1) // R08
        : enh_on ? servo_cfg_pkg::stretch_decode(str_code, 1'b0) // R07
        : servo_cfg_pkg::STRETCH_3P8NS; // R10

    // RF lowpass only applies outside the alternate mode; lead/lag start applies in both
    assign pd_cfg_out.rf_eq_active = !alt_mode_in; // R08
    assign pd_cfg_out.rf_lowpass_sel = pd_word_in[servo_cfg_pkg::EQ_MSB:servo_cfg_pkg::EQ_LSB]; // R11
    assign pd_cfg_out.leadlag_start_freq = (ll_code == servo_cfg_pkg::LL_UNUSED) ? servo_cfg_pkg::LL_10MHZ
        : ll_code; // R12

endmodule

`default_nettype wire

//--- core/servo_cfg_pkg.sv
package servo_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Word layout
    localparam int WORD_W = 16;
    localparam int FIELD_W = 12;
    localparam int CODE_W = 4;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 12;

    // Register codes carried in the top nibble of a control word
    localparam logic [3:0] CODE_SERVO_GAIN = 4'h6;
    localparam logic [3:0] CODE_PD_RF_BW = 4'h7;
    localparam logic [3:0] CODE_CHAN_SEL = 4'h8;
    localparam logic [3:0] CODE_ALT_MODE = 4'hE;
    localparam logic [3:0] CODE_STATUS = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Servo gain and offset factor fields
    localparam int RLF_MSB = 11;
    localparam int RLF_LSB = 8;
    localparam int CLF_MSB = 7;
    localparam int CLF_LSB = 4;
    localparam int DOF_MSB = 3;
    localparam int DOF_LSB = 0;

    // Phase detector and RF bandwidth fields
    localparam int PDLP_BIT = 11;
    localparam int STR_MSB = 9;
    localparam int STR_LSB = 7;
    localparam int FTEST_BIT = 6;
    localparam int ENH_BIT = 5;
    localparam int EQ_MSB = 4;
    localparam int EQ_LSB = 2;
    localparam int LL_MSB = 1;
    localparam int LL_LSB = 0;

    // Channel selection: two bits per channel, A lowest, D highest
    localparam int CHAN_CNT = 4;
    localparam int CHAN_W = 8;
    localparam int CHAN_STRIDE = 2;
    localparam int CHAN_FLIP_OFS = 0;
    localparam int CHAN_SILENCE_OFS = 1;
    localparam int ALT_BIT = 0;

    // Reset values: gains at 0 dB, balanced offset factor, legacy detector
    localparam logic [11:0] RST_SERVO_GAIN = 12'h558;
    localparam logic [11:0] RST_PD_RF_BW = 12'h084;
    localparam logic [7:0] RST_CHAN_SEL = 8'h00;
    localparam logic RST_ALT = 1'b0;

    // Codes and padding used in decode and readback
    localparam logic [1:0] LL_UNUSED = 2'h3;
    localparam logic [1:0] LL_10MHZ = 2'h2;
    localparam logic [2:0] STR_CODE_MAX_ALT = 3'h5;
    localparam logic [3:0] CHAN_PAD = 4'h0;
    localparam logic [10:0] ALT_PAD = 11'h000;
    localparam logic [1:0] STATUS_PAD = 2'h0;
    localparam logic [15:0] RDATA_IDLE = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        STRETCH_1P2NS,
        STRETCH_1P9NS,
        STRETCH_3P8NS,
        STRETCH_7P5NS,
        STRETCH_15NS,
        STRETCH_30NS
    } stretch_type;

    typedef struct packed {
        logic [3:0] radial_lf_gain;
        logic [3:0] central_lf_gain;
        logic [3:0] dyn_offset_factor;
    } servo_cfg_type;

    typedef struct packed {
        logic phase_det_lowpass_sel;
        stretch_type pulse_stretch_time;
        logic rf_eq_active;
        logic [2:0] rf_lowpass_sel;
        logic [1:0] leadlag_start_freq;
    } pd_cfg_type;

    typedef struct packed {
        logic [3:0] silence;
        logic [3:0] polarity_flip;
    } chan_cfg_type;

    ////////////////////////////////////////////////////////////////////////////
    // Register code of a control word
    function automatic logic [3:0] word_code(input logic [15:0] word);
        word_code = word[CODE_MSB:CODE_LSB];
    endfunction

    // Stretch code to time, normal or reversed table; unused codes clamp
    function automatic stretch_type stretch_decode(input logic [2:0] code, input logic alt);
        logic [2:0] idx;
        idx = alt ? code : (STR_CODE_MAX_ALT - 3'h1 - code);
        if (code > STR_CODE_MAX_ALT || (!alt && code >= STR_CODE_MAX_ALT))
            stretch_decode = alt ? STRETCH_1P2NS : STRETCH_30NS;
        else
            stretch_decode = stretch_type'(STR_CODE_MAX_ALT - idx);
    endfunction

endpackage

//--- core/servo_rf_config_registers.sv
// Functional notes
// R01 - Word with top nibble 0110 writes the servo gain and offset factor register.
// R02 - Bits 11..8 of that register set radial low-frequency gain, -15 to +9 dB.
// R03 - Bits 7..4 set central low-frequency gain with the same nine steps.
// R04 - Bits 3..0 set dynamic radial offset factor 0.60..1.35; 1000 is balanced.
// R05 - Word with top nibble 0111 writes the phase detector and RF bandwidth register.
// R06 - Bit 11 picks phase detector lowpass: 0 is 50 MHz, 1 is 10 MHz.
// R07 - Bits 9..7 pick stretch 1.9/3.8/7.5/15/30 ns; 101 unused, normal mode.
// R08 - Alternate timing mode reverses stretch table, adds 1.2 ns, disables other fields; lead/lag start stays active here.
// R09 - Host keeps bit 6 of the detector register at zero; factory test only.
// R10 - Bit 5 low ignores bits 11..6 for fixed legacy; high enables programmability.
// R11 - Bits 4..2 of the detector register select RF channel lowpass bandwidth.
// R12 - Bits 1..0 pick lead/lag start 1, 5 or 10 MHz; 11 unused.
// R13 - Word with top nibble 1000 writes channel selection; bits 11..8 do nothing.
// R14 - Channel selection bits 7, 5, 3 mute channels D, C, B when set.
// R15 - Channel selection bits 6, 4 invert channels D, C when set.
// R16 - Bit 2 inverts B, bit 1 mutes A, bit 0 inverts A.
// R17 - Host never writes unused codes; unused stretch and lead/lag codes map here onto a valid setting.
`timescale 1ns/1ps
`default_nettype none

module servo_rf_config_registers
#(
    parameter logic [11:0] SERVO_GAIN_RESET = servo_cfg_pkg::RST_SERVO_GAIN,
    parameter logic [11:0] PD_RF_BW_RESET = servo_cfg_pkg::RST_PD_RF_BW,
    parameter logic [7:0] CHAN_SEL_RESET = servo_cfg_pkg::RST_CHAN_SEL
)
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    output servo_cfg_pkg::servo_cfg_type servo_cfg_out,
    output servo_cfg_pkg::pd_cfg_type pd_cfg_out,
    output servo_cfg_pkg::chan_cfg_type chan_cfg_out,
    output logic factory_test_bit_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [11:0] servo_gain_r;
    logic [11:0] pd_rf_bw_r;
    logic [7:0] chan_sel_r;
    logic alt_mode_r;
    logic [15:0] rdata_r;
    servo_cfg_pkg::servo_cfg_type servo_cfg_r;
    servo_cfg_pkg::pd_cfg_type pd_cfg_r;
    servo_cfg_pkg::chan_cfg_type chan_cfg_r;
    logic factory_test_r;

    logic [15:0] rdata_nxt;
    servo_cfg_pkg::servo_cfg_type servo_cfg_nxt;
    servo_cfg_pkg::pd_cfg_type pd_cfg_nxt;
    servo_cfg_pkg::chan_cfg_type chan_cfg_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode: target chosen by the code in the word itself
    wire logic [3:0] wr_code = servo_cfg_pkg::word_code(wdata_in);
    wire logic [11:0] wr_field = wdata_in[servo_cfg_pkg::FIELD_W-1:0];
    wire logic wr_servo = wr_in && (wr_code == servo_cfg_pkg::CODE_SERVO_GAIN); // R01
    wire logic wr_pd = wr_in && (wr_code == servo_cfg_pkg::CODE_PD_RF_BW); // R05
    wire logic wr_chan = wr_in && (wr_code == servo_cfg_pkg::CODE_CHAN_SEL); // R13
    wire logic wr_alt = wr_in && (wr_code == servo_cfg_pkg::CODE_ALT_MODE);

    // Servo gain and offset factor register
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            servo_gain_r <= SERVO_GAIN_RESET;
        else if (wr_servo)
            servo_gain_r <= wr_field; // R01
    end

    // Phase detector and RF bandwidth register, test bit kept as written
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            pd_rf_bw_r <= PD_RF_BW_RESET;
        else if (wr_pd)
            pd_rf_bw_r <= wr_field; // R05
    end

    // Channel selection register; upper nibble of the field is dropped
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            chan_sel_r <= CHAN_SEL_RESET;
        else if (wr_chan)
            chan_sel_r <= wr_field[servo_cfg_pkg::CHAN_W-1:0]; // R13
    end

    // Alternate pulse-timing mode register
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            alt_mode_r <= servo_cfg_pkg::RST_ALT;
        else if (wr_alt)
            alt_mode_r <= wr_field[servo_cfg_pkg::ALT_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Servo settings straight from their fields
    assign servo_cfg_nxt.radial_lf_gain = servo_gain_r[servo_cfg_pkg::RLF_MSB:servo_cfg_pkg::RLF_LSB]; // R02
    assign servo_cfg_nxt.central_lf_gain = servo_gain_r[servo_cfg_pkg::CLF_MSB:servo_cfg_pkg::CLF_LSB]; // R03
    assign servo_cfg_nxt.dyn_offset_factor = servo_gain_r[servo_cfg_pkg::DOF_MSB:servo_cfg_pkg::DOF_LSB]; // R04

    // Effective detector settings under the mode bits
    pd_setting_resolve u_resolve
    (
        .pd_word_in(pd_rf_bw_r),
        .alt_mode_in(alt_mode_r),
        .pd_cfg_out(pd_cfg_nxt)
    );

    // Per-channel silence and polarity bits, A at the bottom
    genvar ch;
    generate
        for (ch = 0; ch < servo_cfg_pkg::CHAN_CNT; ch++)
        begin : g_chan
            assign chan_cfg_nxt.silence[ch] =
                chan_sel_r[ch*servo_cfg_pkg::CHAN_STRIDE+servo_cfg_pkg::CHAN_SILENCE_OFS]; // R14 R16
            assign chan_cfg_nxt.polarity_flip[ch] =
                chan_sel_r[ch*servo_cfg_pkg::CHAN_STRIDE+servo_cfg_pkg::CHAN_FLIP_OFS]; // R15 R16
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read mux: data only in the cycle after the strobe
    wire logic rd_servo = addr_in == servo_cfg_pkg::CODE_SERVO_GAIN;
    wire logic rd_pd = addr_in == servo_cfg_pkg::CODE_PD_RF_BW;
    wire logic rd_chan = addr_in == servo_cfg_pkg::CODE_CHAN_SEL;
    wire logic rd_alt = addr_in == servo_cfg_pkg::CODE_ALT_MODE;
    wire logic rd_stat = addr_in == servo_cfg_pkg::CODE_STATUS;

    assign rdata_nxt = !rd_in ? servo_cfg_pkg::RDATA_IDLE
        : rd_servo ? {servo_cfg_pkg::CODE_SERVO_GAIN, servo_gain_r}
        : rd_pd ? {servo_cfg_pkg::CODE_PD_RF_BW, pd_rf_bw_r}
        : rd_chan ? {servo_cfg_pkg::CODE_CHAN_SEL, servo_cfg_pkg::CHAN_PAD, chan_sel_r} // R13
        : rd_alt ? {servo_cfg_pkg::CODE_ALT_MODE, servo_cfg_pkg::ALT_PAD, alt_mode_r}
        : rd_stat ? {servo_cfg_pkg::CODE_STATUS, servo_cfg_pkg::STATUS_PAD, pd_cfg_r}
        : servo_cfg_pkg::RDATA_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Output flip-flops
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdata_r <= servo_cfg_pkg::RDATA_IDLE;
            servo_cfg_r <= servo_cfg_pkg::servo_cfg_type'(SERVO_GAIN_RESET);
            pd_cfg_r <= '0;
            chan_cfg_r <= '0;
            factory_test_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            servo_cfg_r <= servo_cfg_nxt;
            pd_cfg_r <= pd_cfg_nxt;
            chan_cfg_r <= chan_cfg_nxt;
            factory_test_r <= pd_rf_bw_r[servo_cfg_pkg::FTEST_BIT]; // R09
        end
    end

    assign rdata_out = rdata_r;
    assign servo_cfg_out = servo_cfg_r;
    assign pd_cfg_out = pd_cfg_r;
    assign chan_cfg_out = chan_cfg_r;
    assign factory_test_bit_out = factory_test_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    // A write strobe carrying a given register code
    sequence s_wr(logic [3:0] code);
        wr_in && (servo_cfg_pkg::word_code(wdata_in) == code);
    endsequence

    // A read strobe at a given register code
    sequence s_rd(logic [3:0] code);
        rd_in && (addr_in == code);
    endsequence

    chk_servo_store: assert property ( // R01
        s_wr(servo_cfg_pkg::CODE_SERVO_GAIN) |=> servo_gain_r == $past(wdata_in[11:0]))
        else $error("servo gain word not stored");

    chk_servo_hold: assert property ( // R01
        !wr_servo |=> $stable(servo_gain_r))
        else $error("servo gain changed without its code");

    chk_radial_gain: assert property ( // R02
        s_wr(servo_cfg_pkg::CODE_SERVO_GAIN) |=> ##1 servo_cfg_out.radial_lf_gain == $past(wdata_in[11:8], 2))
        else $error("radial gain output wrong");

    chk_central_gain: assert property ( // R03
        s_wr(servo_cfg_pkg::CODE_SERVO_GAIN) |=> ##1 servo_cfg_out.central_lf_gain == $past(wdata_in[7:4], 2))
        else $error("central gain output wrong");

    chk_offset_factor: assert property ( // R04
        s_wr(servo_cfg_pkg::CODE_SERVO_GAIN) |=> ##1 servo_cfg_out.dyn_offset_factor == $past(wdata_in[3:0], 2))
        else $error("offset factor output wrong");

    chk_pd_store: assert property ( // R05
        s_wr(servo_cfg_pkg::CODE_PD_RF_BW) |=> pd_rf_bw_r == $past(wdata_in[11:0]))
        else $error("detector word not stored");

    chk_lowpass_prog: assert property ( // R06
        ($past(resetn_in) && !alt_mode_r && pd_rf_bw_r[5])
        |=> pd_cfg_out.phase_det_lowpass_sel == $past(pd_rf_bw_r[11]))
        else $error("lowpass corner not taken from upper bit");

    chk_stretch_normal: assert property ( // R07
        ($past(resetn_in) && !alt_mode_r && pd_rf_bw_r[5] && pd_rf_bw_r[9:7] == 3'h0)
        |=> pd_cfg_out.pulse_stretch_time == servo_cfg_pkg::STRETCH_1P9NS)
        else $error("normal stretch code 000 not 1.9 ns");

    chk_stretch_alt: assert property ( // R08
        ($past(resetn_in) && alt_mode_r && pd_rf_bw_r[9:7] == 3'h5)
        |=> pd_cfg_out.pulse_stretch_time == servo_cfg_pkg::STRETCH_1P2NS && !pd_cfg_out.rf_eq_active)
        else $error("alternate stretch code 101 not 1.2 ns");

    chk_legacy_fixed: assert property ( // R10
        ($past(resetn_in) && !alt_mode_r && !pd_rf_bw_r[5])
        |=> pd_cfg_out.pulse_stretch_time == servo_cfg_pkg::STRETCH_3P8NS && !pd_cfg_out.phase_det_lowpass_sel)
        else $error("legacy mode not fixed");

    chk_rf_lowpass: assert property ( // R11
        ($past(resetn_in) && !alt_mode_r)
        |=> pd_cfg_out.rf_eq_active && pd_cfg_out.rf_lowpass_sel == $past(pd_rf_bw_r[4:2]))
        else $error("RF lowpass selection wrong");

    chk_leadlag_freq: assert property ( // R12
        ($past(resetn_in) && pd_rf_bw_r[1:0] == 2'h1) |=> pd_cfg_out.leadlag_start_freq == 2'h1)
        else $error("lead/lag start frequency wrong");

    chk_chan_unused: assert property ( // R13
        (rd_in && addr_in == servo_cfg_pkg::CODE_CHAN_SEL) |=> rdata_out[11:8] == 4'h0)
        else $error("unused channel bits read nonzero");

    chk_chan_dc: assert property ( // R14 R15
        s_wr(servo_cfg_pkg::CODE_CHAN_SEL) |=> ##1
        chan_cfg_out.silence[3:1] == {$past(wdata_in[7], 2), $past(wdata_in[5], 2), $past(wdata_in[3], 2)}
        && chan_cfg_out.polarity_flip[3:2] == {$past(wdata_in[6], 2), $past(wdata_in[4], 2)})
        else $error("channel D/C/B control wrong");

    chk_chan_ba: assert property ( // R16
        s_wr(servo_cfg_pkg::CODE_CHAN_SEL) |=> ##1
        chan_cfg_out.polarity_flip[1:0] == {$past(wdata_in[2], 2), $past(wdata_in[0], 2)}
        && chan_cfg_out.silence[0] == $past(wdata_in[1], 2))
        else $error("channel B/A control wrong");

    chk_read_window: assert property (
        !rd_in |=> rdata_out == 16'h0000)
        else $error("read data outside its cycle");

    chk_pd_hold: assert property ( // R05
        !wr_pd |=> $stable(pd_rf_bw_r))
        else $error("detector word changed without its code");

    chk_chan_store: assert property ( // R13
        s_wr(servo_cfg_pkg::CODE_CHAN_SEL) |=> chan_sel_r == $past(wdata_in[7:0]))
        else $error("channel word not stored");

    chk_chan_hold: assert property ( // R13
        !wr_chan |=> $stable(chan_sel_r))
        else $error("channel word changed without its code");

    chk_factory_copy: assert property ( // R09
        s_wr(servo_cfg_pkg::CODE_PD_RF_BW) |=> ##1 factory_test_bit_out == $past(wdata_in[6], 2))
        else $error("factory test bit not copied");

    chk_alt_fields: assert property ( // R08
        ($past(resetn_in) && alt_mode_r)
        |=> !pd_cfg_out.phase_det_lowpass_sel && !pd_cfg_out.rf_eq_active)
        else $error("alternate mode left detector fields active");

    chk_alt_reverse: assert property ( // R08
        ($past(resetn_in) && alt_mode_r && pd_rf_bw_r[9:7] == 3'h0)
        |=> pd_cfg_out.pulse_stretch_time == servo_cfg_pkg::STRETCH_30NS)
        else $error("alternate stretch code 000 not 30 ns");

    chk_stretch_top: assert property ( // R07
        ($past(resetn_in) && !alt_mode_r && pd_rf_bw_r[5] && pd_rf_bw_r[9:7] == 3'h4)
        |=> pd_cfg_out.pulse_stretch_time == servo_cfg_pkg::STRETCH_30NS)
        else $error("normal stretch code 100 not 30 ns");

    chk_leadlag_pass: assert property ( // R12
        ($past(resetn_in) && pd_rf_bw_r[1:0] != 2'h3)
        |=> pd_cfg_out.leadlag_start_freq == $past(pd_rf_bw_r[1:0]))
        else $error("lead/lag start code not passed through");

    chk_read_servo: assert property ( // R01
        s_rd(servo_cfg_pkg::CODE_SERVO_GAIN)
        |=> rdata_out == {servo_cfg_pkg::CODE_SERVO_GAIN, $past(servo_gain_r)})
        else $error("servo gain readback wrong");

    chk_read_pd: assert property ( // R05
        s_rd(servo_cfg_pkg::CODE_PD_RF_BW)
        |=> rdata_out == {servo_cfg_pkg::CODE_PD_RF_BW, $past(pd_rf_bw_r)})
        else $error("detector word readback wrong");

    chk_read_alt: assert property ( // R08
        s_rd(servo_cfg_pkg::CODE_ALT_MODE)
        |=> rdata_out == {servo_cfg_pkg::CODE_ALT_MODE, 11'h000, $past(alt_mode_r)})
        else $error("alternate mode readback wrong");

endmodule

`default_nettype wire

//--- verification/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
(
    input wire logic clk_in,
    output var logic [3:0] addr_out,
    output var logic [15:0] wdata_out,
    output var logic wr_out,
    output var logic rd_out,
    input wire logic [15:0] rdata_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus idle at time zero, no strobe raised
    initial
    begin
        addr_out = 4'h0;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // One-cycle write strobe; a detector word is cleaned of test bit 6 and lead/lag code 11, stretch codes pass unchanged
    task automatic write_word(input logic [15:0] w);
        logic [15:0] v;
        v = w;
        if (v[15:12] == 4'h7)
        begin
            v[6] = 1'b0;
            if (v[1:0] == 2'h3)
                v[1:0] = 2'h2;
        end
        @(posedge clk_in);
        wdata_out <= v;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~v; // Stale data is inverted; with the strobe low it writes nothing
    endtask

    // One-cycle read strobe; data taken in the cycle after it
    task automatic read_word(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        d = rdata_in;
    endtask

endmodule

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;

    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata_out;
    servo_cfg_pkg::servo_cfg_type servo_cfg_out;
    servo_cfg_pkg::pd_cfg_type pd_cfg_out;
    servo_cfg_pkg::chan_cfg_type chan_cfg_out;
    logic factory_test_bit_out;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    servo_cfg_pkg::pd_cfg_type pd_exp;
    logic [15:0] w;
    logic [15:0] rv;
    logic [7:0] ch_exp;
    logic [2:0] sb;
    logic [1:0] ll;
    servo_cfg_pkg::stretch_type str_norm [0:4];
    servo_cfg_pkg::stretch_type str_alt [0:5];

    always #12.5 clk_in = ~clk_in;

    host_bus_model i_host
    (
        .clk_in(clk_in),
        .addr_out(addr),
        .wdata_out(wdata),
        .wr_out(wr),
        .rd_out(rd),
        .rdata_in(rdata_out)
    );

    servo_rf_config_registers i_dut
    (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .addr_in(addr),
        .wdata_in(wdata),
        .wr_in(wr),
        .rd_in(rd),
        .rdata_out(rdata_out),
        .servo_cfg_out(servo_cfg_out),
        .pd_cfg_out(pd_cfg_out),
        .chan_cfg_out(chan_cfg_out),
        .factory_test_bit_out(factory_test_bit_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Compare tasks and closing report
    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_cfg(input string name, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Write a word and wait until the configuration outputs follow it
    task automatic put(input logic [15:0] word);
        i_host.write_word(word);
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // Read a register and check the one-cycle data window
    task automatic get(input logic [3:0] a, input logic [15:0] exp);
        i_host.read_word(a, rv);
        check_word("read data", exp, rv);
        @(posedge clk_in);
        #1;
        check_word("read data after window", 16'h0000, rdata_out);
    endtask

    // Expected settings after reset, also after refused writes
    task automatic check_reset_state;
        pd_exp.phase_det_lowpass_sel = 1'b0;
        pd_exp.pulse_stretch_time = servo_cfg_pkg::STRETCH_3P8NS;
        pd_exp.rf_eq_active = 1'b1;
        pd_exp.rf_lowpass_sel = 3'h1;
        pd_exp.leadlag_start_freq = 2'h0;
        check_cfg("servo gains", 12'h558, servo_cfg_out);
        check_cfg("detector cfg", {2'h0, pd_exp}, {2'h0, pd_cfg_out});
        check_cfg("channel cfg", 12'h000, {4'h0, chan_cfg_out});
    endtask

    // Hang guard
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles >= 4000)
        begin
            err_total++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        str_norm = '{servo_cfg_pkg::STRETCH_1P9NS, servo_cfg_pkg::STRETCH_3P8NS, servo_cfg_pkg::STRETCH_7P5NS,
                     servo_cfg_pkg::STRETCH_15NS, servo_cfg_pkg::STRETCH_30NS};
        str_alt = '{servo_cfg_pkg::STRETCH_30NS, servo_cfg_pkg::STRETCH_15NS, servo_cfg_pkg::STRETCH_7P5NS,
                    servo_cfg_pkg::STRETCH_3P8NS, servo_cfg_pkg::STRETCH_1P9NS, servo_cfg_pkg::STRETCH_1P2NS};
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        check_reset_state();
        get(4'h6, 16'h6558);
        get(4'h7, 16'h7084);
        get(4'h8, 16'h8000);
        // Words with foreign codes change nothing; unmapped read gives zero
        put(16'h5FFF);
        put(16'h9FFF);
        put(16'hFFFF);
        check_reset_state();
        get(4'h3, 16'h0000);
        // Both gain fields over all nine steps, offset factor over its upper codes
        for (int g = 0; g <= 8; g++)
        begin
            w = {4'h6, 4'(g), 4'(8 - g), 4'(g + 7)};
            put(w);
            check_cfg("servo gains", w[11:0], servo_cfg_out);
            get(4'h6, w);
        end
        // Stretch, lowpass, bandwidth and start frequency, legacy and programmable
        for (int en = 0; en <= 1; en++)
        begin
            for (int s = 0; s <= 4; s++)
            begin
                sb = 3'(s);
                ll = 2'(s % 3);
                w = {4'h7, sb[0], ~sb[0], sb, 1'b1, 1'(en), sb, ll};
                put(w);
                pd_exp.phase_det_lowpass_sel = (en == 1) ? sb[0] : 1'b0;
                pd_exp.pulse_stretch_time = (en == 1) ? str_norm[s] : servo_cfg_pkg::STRETCH_3P8NS;
                pd_exp.rf_eq_active = 1'b1;
                pd_exp.rf_lowpass_sel = sb;
                pd_exp.leadlag_start_freq = ll;
                check_cfg("detector cfg", {2'h0, pd_exp}, {2'h0, pd_cfg_out});
                check_word("factory bit", 16'h0000, {15'h0, factory_test_bit_out});
                get(4'hF, {4'hF, 2'h0, pd_exp});
            end
        end
        // Alternate timing mode reverses the stretch table
        put(16'hE001);
        get(4'hE, 16'hE001);
        for (int s = 0; s <= 5; s++)
        begin
            sb = 3'(s);
            put({4'h7, 2'h3, sb, 1'b0, 1'b1, 3'h1, 2'h1});
            pd_exp.phase_det_lowpass_sel = 1'b0;
            pd_exp.pulse_stretch_time = str_alt[s];
            pd_exp.rf_eq_active = 1'b0;
            pd_exp.rf_lowpass_sel = 3'h1;
            pd_exp.leadlag_start_freq = 2'h1;
            check_cfg("detector cfg", {2'h0, pd_exp}, {2'h0, pd_cfg_out});
        end
        put(16'hE000);
        get(4'hE, 16'hE000);
        // Each channel bit alone; unused upper bits read back as zero
        for (int b = 0; b < 8; b++)
        begin
            w = {4'h8, 4'hF, 8'(1 << b)};
            put(w);
            for (int k = 0; k < 4; k++)
            begin
                ch_exp[4 + k] = w[2 * k + 1];
                ch_exp[k] = w[2 * k];
            end
            check_cfg("channel cfg", {4'h0, ch_exp}, {4'h0, chan_cfg_out});
            get(4'h8, {8'h80, w[7:0]});
        end
        test_done();
    end

endmodule

`default_nettype wire
